// file: core/trace_pkg.sv
// shared constants and record types for the trace capture and output block
package trace_pkg;

    // address the core jumps to on reset; that jump is never traced
    localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;

    // record kinds, sent in the upper half of each header nibble
    localparam logic [1:0] KIND_BRANCH = 2'h0;
    localparam logic [1:0] KIND_EXCEPT = 2'h1;
    localparam logic [1:0] KIND_SOFT = 2'h2;
    localparam logic [1:0] KIND_MONITOR = 2'h3;

    // address compression codes, lower half of the header nibble
    localparam logic [1:0] SIZE_4 = 2'h0;
    localparam logic [1:0] SIZE_8 = 2'h1;
    localparam logic [1:0] SIZE_16 = 2'h2;
    localparam logic [1:0] SIZE_32 = 2'h3;

    // nibbles taken by a software trace register value
    localparam logic [4:0] SOFT_DATA_NIBBLES = 5'h08;

    // reference address used for compression after reset
    localparam logic [31:0] LAST_ADDR_RESET = 32'h0000_0000;

    // one captured trace record
    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] addr;
        logic [31:0] data;
    } rec_type;

    // one nibble on its way to the trace data lines
    typedef struct packed {
        logic [3:0] nib;
        logic last;
    } nib_type;

endpackage

// file: core/nibble_skid.sv
// two-entry buffer with valid and ready on both sides
module nibble_skid #(
    parameter int WIDTH = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] cnt;
        logic rd;
    } skid_state_type;

    skid_state_type s_r;
    skid_state_type s_nxt;
    logic push;
    logic pop;

    // ready depends only on the stored count, so no path runs back to the source
    assign in_ready_o = (s_r.cnt != 2'h2);
    assign out_valid_o = (s_r.cnt != 2'h0);
    assign out_data_o = s_r.mem[s_r.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // write slot follows the read slot when one entry is held
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.rd ^ (s_r.cnt == 2'h1)] = in_data_i;
        end
        if (pop)
        begin
            s_nxt.rd = ~s_r.rd;
        end
        s_nxt.cnt = 2'(s_r.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

// file: core/trace_capture_output.sv
// trace capture, trace buffer and nibble-wide trace port output
//////////////////////////////////////////////////////////////////////////////
module trace_capture_output #(
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic trace_en_i,
    input wire logic realtime_mode_i,
    input wire logic overwrite_mode_i,
    input wire logic byte_mode_req_i,
    input wire logic br_valid_i,
    input wire logic [31:0] br_src_i,
    input wire logic [31:0] br_dst_i,
    input wire logic [31:0] br_next_pc_i,
    input wire logic br_cond_i,
    input wire logic br_disp_zero_i,
    input wire logic br_reset_i,
    input wire logic br_except_i,
    input wire logic br_complete_i,
    input wire logic in_monitor_i,
    input wire logic sw_valid_i,
    input wire logic [31:0] sw_pc_i,
    input wire logic [31:0] sw_reg_i,
    input wire logic trace_port_clock_i,
    output logic [3:0] trace_data_lines_o,
    output logic trace_frame_o,
    output logic trace_end_o,
    output logic cpu_stall_o,
    output logic buffer_full_o,
    output logic trace_stopped_o,
    output logic trace_dropped_o,
    output logic byte_mode_refused_o
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);

    typedef struct packed {
        trace_pkg::rec_type [DEPTH-1:0] ring;
        logic [PTR_W-1:0] wr, rd;
        logic [PTR_W:0] cnt;
        logic full, stopped, stall, dropped, refused;
        logic [31:0] last_addr;
        trace_pkg::rec_type cur;
        logic busy;
        logic [4:0] idx, total;
        logic [1:0] size;
        logic [2:0] sync;
        logic [3:0] pin_data;
        logic pin_valid, pin_last;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    logic fall, br_ok, ev_ok, bi_ready, bo_valid, push;
    trace_pkg::rec_type ev_rec;
    trace_pkg::nib_type bin, bo;
    logic [4:0] aidx, didx, an;

    // smallest field whose upper bits match the previous address
    function automatic logic [1:0] addr_size(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a ^ b;
        if (d[31:4] == 28'h0)
            return trace_pkg::SIZE_4;
        else if (d[31:8] == 24'h0)
            return trace_pkg::SIZE_8;
        else if (d[31:16] == 16'h0)
            return trace_pkg::SIZE_16;
        else
            return trace_pkg::SIZE_32;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // event filtering and record building
    // untraced branches
    assign br_ok = br_valid_i & ~(br_cond_i & br_disp_zero_i)
        & ~(br_reset_i & (br_dst_i == trace_pkg::RESET_VECTOR));
    assign ev_ok = br_ok | sw_valid_i;

    // branch wins a shared cycle; the core never issues both at once
    always_comb
    begin
        ev_rec = '0;
        if (br_ok)
        begin
            ev_rec.addr = (br_except_i & br_complete_i) ? br_next_pc_i : br_src_i;
            if (in_monitor_i)
                ev_rec.kind = trace_pkg::KIND_MONITOR;
            else if (br_except_i)
                ev_rec.kind = trace_pkg::KIND_EXCEPT;
            else
                ev_rec.kind = trace_pkg::KIND_BRANCH;
        end
        else
        begin
            ev_rec.kind = trace_pkg::KIND_SOFT;
            ev_rec.addr = sw_pc_i;
            ev_rec.data = sw_reg_i;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // nibble serializer feeding the output buffer
    assign aidx = 5'(s_r.idx - 5'h01);
    assign an = 5'(5'h01 << s_r.size);
    assign didx = 5'(aidx - an);
    assign push = s_r.busy & bi_ready;
    assign fall = s_r.sync[2] & ~s_r.sync[1];

    // header first, then address nibbles low first, then register data
    always_comb
    begin
        bin.last = (s_r.idx == 5'(s_r.total - 5'h01));
        if (s_r.idx == 5'h00)
            bin.nib = {s_r.cur.kind, s_r.size};
        else if (aidx < an)
            bin.nib = s_r.cur.addr[{aidx[2:0], 2'b00} +: 4];
        else
            bin.nib = s_r.cur.data[{didx[2:0], 2'b00} +: 4];
    end

    // a port clock stall backs up here and then stops the serializer
    nibble_skid #(
        .WIDTH(5)
    ) u_buf (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(s_r.busy),
        .in_data_i(bin),
        .in_ready_o(bi_ready),
        .out_valid_o(bo_valid),
        .out_data_o(bo),
        .out_ready_i(fall)
    );

    //////////////////////////////////////////////////////////////////////////
    // state update
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.dropped = 1'b0;
        // port clock sampled twice before its edge is looked for
        s_nxt.sync = {s_r.sync[1:0], trace_port_clock_i};
        if (fall)
        begin
            s_nxt.pin_valid = bo_valid;
            s_nxt.pin_data = bo_valid ? bo.nib : 4'h0;
            s_nxt.pin_last = bo_valid & bo.last;
        end
        if (push)
        begin
            s_nxt.idx = 5'(s_r.idx + 5'h01);
            s_nxt.busy = ~bin.last;
        end
        if (!s_r.busy && s_r.cnt != '0)
        begin
            s_nxt.cur = s_r.ring[s_r.rd];
            s_nxt.rd = PTR_W'(s_r.rd + 1'b1);
            s_nxt.cnt = (PTR_W + 1)'(s_r.cnt - 1'b1);
            s_nxt.busy = 1'b1;
            s_nxt.idx = 5'h00;
            s_nxt.size = addr_size(s_r.ring[s_r.rd].addr, s_r.last_addr);
            s_nxt.total = 5'(5'h01 + (5'h01 << s_nxt.size)
                + ((s_r.ring[s_r.rd].kind == trace_pkg::KIND_SOFT)
                ? trace_pkg::SOFT_DATA_NIBBLES : 5'h00));
            s_nxt.last_addr = s_r.ring[s_r.rd].addr;
        end
        if (trace_en_i && ev_ok && !s_r.stopped)
        begin
            if (s_nxt.cnt != FULL_CNT)
            begin
                s_nxt.ring[s_r.wr] = ev_rec;
                s_nxt.wr = PTR_W'(s_r.wr + 1'b1);
                s_nxt.cnt = (PTR_W + 1)'(s_nxt.cnt + 1'b1);
            end
            else if (realtime_mode_i && overwrite_mode_i)
            begin
                s_nxt.ring[s_r.wr] = ev_rec;
                s_nxt.wr = PTR_W'(s_r.wr + 1'b1);
                s_nxt.rd = PTR_W'(s_nxt.rd + 1'b1);
                s_nxt.dropped = 1'b1;
            end
            else
            begin
                s_nxt.stopped = realtime_mode_i;
                s_nxt.dropped = 1'b1;
            end
        end
        if (!trace_en_i)
            s_nxt.stopped = 1'b0;
        s_nxt.stall = ~realtime_mode_i & trace_en_i
            & (s_r.stall | s_r.cnt == FULL_CNT | s_nxt.cnt == FULL_CNT)
            & ~(s_nxt.cnt == '0 & ~s_nxt.busy);
        s_nxt.full = (s_nxt.cnt == FULL_CNT);
        s_nxt.refused = byte_mode_req_i;
    end

    // async reset loads constants only
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // outputs straight from state
    assign trace_data_lines_o = s_r.pin_data;
    assign trace_frame_o = s_r.pin_valid;
    assign trace_end_o = s_r.pin_last;
    assign cpu_stall_o = s_r.stall;
    assign buffer_full_o = s_r.full;
    assign trace_stopped_o = s_r.stopped;
    assign trace_dropped_o = s_r.dropped;
    assign byte_mode_refused_o = s_r.refused;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    property p_soft_rec;
        (trace_en_i && sw_valid_i && !br_valid_i && !s_r.stopped && s_r.cnt == '0)
        |=> s_r.ring[$past(s_r.wr)] == {trace_pkg::KIND_SOFT, $past(sw_pc_i), $past(sw_reg_i)};
    endproperty
    a_soft_rec: assert property (p_soft_rec) else $error("soft record wrong");
    property p_rt_nostall;
        $past(realtime_mode_i) |-> !cpu_stall_o;
    endproperty
    a_rt_nostall: assert property (p_rt_nostall) else $error("realtime stall");
    property p_nrt_stall;
        (!realtime_mode_i && trace_en_i && s_r.cnt == FULL_CNT) |=> cpu_stall_o;
    endproperty
    a_nrt_stall: assert property (p_nrt_stall) else $error("no stall on full");
    property p_overwrite;
        (realtime_mode_i && overwrite_mode_i && trace_en_i && ev_ok && s_r.busy
            && s_r.cnt == FULL_CNT && !s_r.stopped)
        |=> s_r.cnt == FULL_CNT && s_r.rd == PTR_W'($past(s_r.rd) + 1'b1);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("oldest not replaced");
    property p_stop;
        (realtime_mode_i && !overwrite_mode_i && trace_en_i && ev_ok && s_r.busy
            && s_r.cnt == FULL_CNT)
        |=> s_r.stopped && s_r.wr == $past(s_r.wr) && !cpu_stall_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mode still records");
    property p_pin_edge;
        $changed(trace_data_lines_o) |-> $past(fall);
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("data moved off edge");
    property p_byte_refused;
        byte_mode_req_i |=> byte_mode_refused_o;
    endproperty
    a_byte_refused: assert property (p_byte_refused) else $error("byte mode taken");
    property p_exc_addr;
        (trace_en_i && br_ok && br_except_i && br_complete_i && !s_r.stopped
            && s_r.cnt == '0)
        |=> s_r.ring[$past(s_r.wr)].addr == $past(br_next_pc_i);
    endproperty
    a_exc_addr: assert property (p_exc_addr) else $error("exception addr wrong");
    property p_no_zero_disp;
        (br_valid_i && br_cond_i && br_disp_zero_i && !sw_valid_i) |=> s_r.wr == $past(s_r.wr);
    endproperty
    a_no_zero_disp: assert property (p_no_zero_disp) else $error("zero disp traced");
    property p_no_reset_jump;
        (br_valid_i && br_reset_i && br_dst_i == trace_pkg::RESET_VECTOR && !sw_valid_i)
        |=> s_r.wr == $past(s_r.wr);
    endproperty
    a_no_reset_jump: assert property (p_no_reset_jump) else $error("reset jump traced");
endmodule

// file: bench/trace_probe_model.sv
// emulator probe model: drives the trace port clock and rebuilds records
module trace_probe_model (
    input wire logic run_i,
    input wire logic [3:0] trace_data_lines_i,
    input wire logic trace_frame_i,
    input wire logic trace_end_i,
    output logic trace_port_clock_o,
    output int n_rec_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hdr_mem [64];
    logic [31:0] addr_mem [64];
    logic [31:0] data_mem [64];
    logic [3:0] hdr;
    logic [31:0] last = trace_pkg::LAST_ADDR_RESET;
    logic [31:0] addr;
    logic [31:0] data;
    int pos = 0;
    //////////////////////////////////////////////////////////////////////////
    // clock stands low between drains, 64 ns period while running
    initial
    begin
        trace_port_clock_o = 1'b0;
        n_rec_o = 0;
        forever
        begin
            #32;
            if (run_i || trace_port_clock_o)
                trace_port_clock_o = ~trace_port_clock_o;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // pins taken as trace port
    always @(posedge trace_port_clock_o)
    begin
        if (trace_frame_i === 1'b1)
        begin
            if (pos == 0)
            begin
                hdr = trace_data_lines_i;
                addr = last;
                data = 32'h0000_0000;
            end
            else if (pos <= (1 << hdr[1:0]))
                addr[4 * (pos - 1) +: 4] = trace_data_lines_i;
            else if (pos <= (1 << hdr[1:0]) + 8)
                data[4 * (pos - 1 - (1 << hdr[1:0])) +: 4] = trace_data_lines_i;
            pos++;
            if (trace_end_i === 1'b1)
            begin
                hdr_mem[n_rec_o % 64] = hdr;
                addr_mem[n_rec_o % 64] = addr;
                data_mem[n_rec_o % 64] = data;
                last = addr;
                n_rec_o++;
                pos = 0;
            end
        end
    end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the trace capture and output block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] hdr;
        logic [31:0] addr;
        logic [31:0] data;
    } exp_type;
    // filter table: {cond, disp zero, reset, except, complete, monitor}
    localparam logic [5:0] FLG [6] = '{6'h30, 6'h08, 6'h20, 6'h06, 6'h04, 6'h05};
    localparam logic [1:0] KND [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3};
    logic clk_sys_i, rst_i, trace_en_i, realtime_mode_i, overwrite_mode_i, byte_mode_req_i;
    logic br_valid_i, br_cond_i, br_disp_zero_i, br_reset_i, br_except_i, br_complete_i;
    logic in_monitor_i, sw_valid_i, trace_port_clock_i, run, stall_seen;
    logic [31:0] br_src_i, br_dst_i, br_next_pc_i, sw_pc_i, sw_reg_i, a, d;
    logic [31:0] prev = trace_pkg::LAST_ADDR_RESET;
    logic [3:0] trace_data_lines_o;
    logic trace_frame_o, trace_end_o, cpu_stall_o, buffer_full_o, trace_stopped_o;
    logic trace_dropped_o, byte_mode_refused_o;
    int n_rec, fails = 0, n_compared = 0, taken = 0, drops = 0;
    int seed = 32'hffeb;
    exp_type exp_q [$];
    //////////////////////////////////////////////////////////////////////////
    trace_capture_output #(
        .DEPTH(2)
    ) dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trace_en_i(trace_en_i),
        .realtime_mode_i(realtime_mode_i),
        .overwrite_mode_i(overwrite_mode_i),
        .byte_mode_req_i(byte_mode_req_i),
        .br_valid_i(br_valid_i),
        .br_src_i(br_src_i),
        .br_dst_i(br_dst_i),
        .br_next_pc_i(br_next_pc_i),
        .br_cond_i(br_cond_i),
        .br_disp_zero_i(br_disp_zero_i),
        .br_reset_i(br_reset_i),
        .br_except_i(br_except_i),
        .br_complete_i(br_complete_i),
        .in_monitor_i(in_monitor_i),
        .sw_valid_i(sw_valid_i),
        .sw_pc_i(sw_pc_i),
        .sw_reg_i(sw_reg_i),
        .trace_port_clock_i(trace_port_clock_i),
        .trace_data_lines_o(trace_data_lines_o),
        .trace_frame_o(trace_frame_o),
        .trace_end_o(trace_end_o),
        .cpu_stall_o(cpu_stall_o),
        .buffer_full_o(buffer_full_o),
        .trace_stopped_o(trace_stopped_o),
        .trace_dropped_o(trace_dropped_o),
        .byte_mode_refused_o(byte_mode_refused_o)
    );
    trace_probe_model probe (
        .run_i(run),
        .trace_data_lines_i(trace_data_lines_o),
        .trace_frame_i(trace_frame_o),
        .trace_end_i(trace_end_o),
        .trace_port_clock_o(trace_port_clock_i),
        .n_rec_o(n_rec)
    );
    // 125 MHz system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // stall and loss watch, sampled mid-cycle to stay off the edge
    always @(negedge clk_sys_i)
    begin
        if (trace_dropped_o === 1'b1)
            drops++;
        if (cpu_stall_o === 1'b1)
            stall_seen = 1'b1;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // address sharing the upper bits of p, low nibbles random
    function automatic logic [31:0] near(input logic [31:0] p, input logic [1:0] sel);
        logic [31:0] mask;
        mask = 32'((64'h1 << (4 << sel)) - 64'h1);
        return (p & ~mask) | ($random(seed) & mask);
    endfunction
    function automatic logic [1:0] size_of(input logic [31:0] p, input logic [31:0] x);
        if (x[31:4] == p[31:4])
            return trace_pkg::SIZE_4;
        if (x[31:8] == p[31:8])
            return trace_pkg::SIZE_8;
        if (x[31:16] == p[31:16])
            return trace_pkg::SIZE_16;
        return trace_pkg::SIZE_32;
    endfunction
    task automatic want(input logic [1:0] k, input logic [31:0] x, input logic [31:0] v);
        exp_q.push_back('{hdr: {k, size_of(prev, x)}, addr: x, data: v});
        prev = x;
    endtask
    // one-cycle event pulse; next call always starts a fresh edge
    task automatic fire(input logic sw, input logic [31:0] x, input logic [31:0] y,
        input logic [5:0] f);
        @(posedge clk_sys_i);
        sw_valid_i <= sw;
        br_valid_i <= !sw;
        {sw_pc_i, br_src_i, sw_reg_i, br_dst_i} <= {x, x, y, y};
        br_next_pc_i <= x + 32'h2;
        {br_cond_i, br_disp_zero_i, br_reset_i, br_except_i, br_complete_i, in_monitor_i} <= f;
        @(posedge clk_sys_i);
        sw_valid_i <= 1'b0;
        br_valid_i <= 1'b0;
    endtask
    task automatic burst(input int n);
        stall_seen = 1'b0;
        drops = 0;
        for (int i = 0; i < n; i++)
            fire(1'b1, a + i, a, 6'h00);
        a = a + n - 1;
        @(negedge clk_sys_i);
    endtask
    // run the port until no record arrives for 400 cycles
    task automatic drain();
        int last, still;
        run = 1'b1;
        last = n_rec;
        still = 0;
        for (int i = 0; i < 20000 && still < 400; i++)
        begin
            @(posedge clk_sys_i);
            still = (n_rec == last) ? still + 1 : 0;
            last = n_rec;
        end
        run = 1'b0;
    endtask
    task automatic skip_all();
        taken = n_rec;
        if (n_rec > 0)
            prev = probe.addr_mem[(n_rec - 1) % 64];
        exp_q.delete();
    endtask
    task automatic compare_all(input string name);
        exp_type e;
        check("record count", 32'(n_rec - taken), 32'(exp_q.size()));
        while (exp_q.size() > 0 && taken < n_rec)
        begin
            e = exp_q.pop_front();
            check("header", 32'(probe.hdr_mem[taken % 64]), 32'(e.hdr));
            check("address", probe.addr_mem[taken % 64], e.addr);
            check("register", probe.data_mem[taken % 64], e.data);
            taken++;
        end
        skip_all();
        $display("test %s done", name);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        {br_valid_i, sw_valid_i, br_cond_i, br_disp_zero_i, br_reset_i, run} = '0;
        {br_except_i, br_complete_i, in_monitor_i, stall_seen} = '0;
        {br_src_i, br_dst_i, br_next_pc_i, sw_pc_i, sw_reg_i, a, d} = '0;
        {trace_en_i, realtime_mode_i, overwrite_mode_i, byte_mode_req_i} = 4'hF;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // software records at every compression size
        for (int i = 0; i < 12; i++)
        begin
            a = near(prev, 2'(i));
            d = $random(seed);
            fire(1'b1, a, d, 6'h00);
            want(trace_pkg::KIND_SOFT, a, d);
            drain();
        end
        check("byte mode refused", 32'(byte_mode_refused_o), 32'h1);
        compare_all("software");
        // branch filters and record kinds
        for (int i = 0; i < 6; i++)
        begin
            a = near(prev, 2'(i));
            fire(1'b0, a, (i == 1) ? trace_pkg::RESET_VECTOR : a + 32'h40, FLG[i]);
            if (i > 1)
                want(KND[i], (i == 3) ? a + 32'h2 : a, 32'h0);
            drain();
        end
        compare_all("branch");
        // realtime overwrite, port held still so the ring overflows
        // survivors: the record already loaded, then the two newest
        want(trace_pkg::KIND_SOFT, a, a);
        want(trace_pkg::KIND_SOFT, a + 32'h4, a);
        want(trace_pkg::KIND_SOFT, a + 32'h5, a);
        burst(6);
        check("stall realtime", 32'(stall_seen), 32'h0);
        check("drops seen", 32'(drops > 0), 32'h1);
        check("full flag", 32'(buffer_full_o), 32'h1);
        drain();
        check("newest kept", probe.addr_mem[(n_rec - 1) % 64], a);
        compare_all("overwrite");
        // stop when full, then clear by disabling
        overwrite_mode_i <= 1'b0;
        // loaded record plus two ring entries get out, the rest are refused
        want(trace_pkg::KIND_SOFT, a, a);
        want(trace_pkg::KIND_SOFT, a + 32'h1, a);
        want(trace_pkg::KIND_SOFT, a + 32'h2, a);
        burst(6);
        check("stopped", 32'(trace_stopped_o), 32'h1);
        check("stall stop", 32'(stall_seen), 32'h0);
        drain();
        compare_all("stop full");
        fire(1'b1, a, a, 6'h00);
        drain();
        check("nothing after stop", 32'(n_rec - taken), 32'h0);
        trace_en_i <= 1'b0;
        byte_mode_req_i <= 1'b0;
        @(posedge clk_sys_i);
        trace_en_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("stop cleared", 32'(trace_stopped_o), 32'h0);
        check("byte mode idle", 32'(byte_mode_refused_o), 32'h0);
        compare_all("stop");
        // non-realtime with overwrite policy: stall instead of loss
        realtime_mode_i <= 1'b0;
        overwrite_mode_i <= 1'b1;
        run = 1'b1;
        stall_seen = 1'b0;
        drops = 0;
        for (int i = 0; i < 8; i++)
        begin
            a = near(prev, 2'(i));
            d = $random(seed);
            repeat (2) @(negedge clk_sys_i);
            for (int k = 0; k < 5000 && cpu_stall_o !== 1'b0; k++)
                @(negedge clk_sys_i);
            fire(1'b1, a, d, 6'h00);
            want(trace_pkg::KIND_SOFT, a, d);
        end
        drain();
        check("stall nonrealtime", 32'(stall_seen), 32'h1);
        check("no loss", 32'(drops), 32'h0);
        compare_all("nonrealtime");
        report_and_stop();
    end
endmodule
